// ---- bxt_pkg.sv ----
// constants and crossing word types for the registered bus transceiver
// assumes one ref_clk domain for registers and one fwd_clock link domain
package bxt_pkg;

    localparam int BXT_W = 17;

    // register byte addresses
    localparam logic [3:0] BXT_ADDR_CTRL = 4'h0;
    localparam logic [3:0] BXT_ADDR_STAT = 4'h4;
    localparam logic [3:0] BXT_ADDR_FWD  = 4'h8;
    localparam logic [3:0] BXT_ADDR_REV  = 4'hc;

    // control register fields
    localparam int BXT_CTRL_W         = 6;
    localparam int BXT_FWD_OE_N_BIT   = 0;
    localparam int BXT_FWD_CE_N_BIT   = 1;
    localparam int BXT_FWD_LATCH_BIT  = 2;
    localparam int BXT_REV_OE_N_BIT   = 3;
    localparam int BXT_REV_CE_N_BIT   = 4;
    localparam int BXT_REV_LATCH_BIT  = 5;
    localparam logic [5:0] BXT_CTRL_RST = 6'h1b;

    // status register fields
    localparam int BXT_STAT_FWD_OE_N_BIT = 0;
    localparam int BXT_STAT_BCLK_BIT     = 1;

    typedef struct packed {
        logic [BXT_W-1:0] data;
        logic             ce_n;
        logic             oe_n;
        logic             latch_open;
    } bxt_cmd_type;

    typedef struct packed {
        logic [BXT_W-1:0] store;
        logic             oe_n;
        logic             cap;
    } bxt_rpt_type;

endpackage

// ---- bxt_link_if.sv ----
// carrier between the register-side core and the fwd_clock link stage
// assumes toggle handshakes: words stay stable until acknowledged
`timescale 1ns/100ps
interface bxt_link_if;
    import bxt_pkg::*;

    bxt_cmd_type cmd;
    logic        cmd_tgl;
    logic        cmd_ack_tgl;
    bxt_rpt_type rpt;
    logic        rpt_tgl;
    logic        rpt_ack_tgl;
    logic        edge_tgl;

    modport ref_side (
        output cmd, cmd_tgl, rpt_ack_tgl,
        input  cmd_ack_tgl, rpt, rpt_tgl, edge_tgl
    );
    modport link_side (
        input  cmd, cmd_tgl, rpt_ack_tgl,
        output cmd_ack_tgl, rpt, rpt_tgl, edge_tgl
    );
endinterface

// ---- bxt_fwd_link.sv ----
// forward clocked stage and output enable register on the link clock
// assumes sys_rst comes from the ref_clk domain and is resynchronised here
`timescale 1ns/100ps
module bxt_fwd_link
    import bxt_pkg::*;
(
    // link clock and reset
    input  wire logic   fwd_clock,
    input  wire logic   sys_rst,
    // crossing to the core
    bxt_link_if.link_side lnk
);

    typedef struct packed {
        logic        rst_s1;
        logic        rst_s2;
        logic        req_s1;
        logic        req_s2;
        logic        ack;
        bxt_cmd_type cmd;
        logic [BXT_W-1:0] store;
        logic        oe_n;
        logic        cap;
        logic        etg;
        logic        rack_s1;
        logic        rack_s2;
        bxt_rpt_type rpt;
        logic        rpt_tgl;
    } bxt_link_state_type;

    bxt_link_state_type s_ff;
    bxt_link_state_type nxt_s;

    always_comb begin
        nxt_s         = s_ff;
        nxt_s.rst_s1  = sys_rst;
        nxt_s.rst_s2  = s_ff.rst_s1;
        nxt_s.req_s1  = lnk.cmd_tgl;
        nxt_s.req_s2  = s_ff.req_s1;
        nxt_s.rack_s1 = lnk.rpt_ack_tgl;
        nxt_s.rack_s2 = s_ff.rack_s1;
        if (s_ff.rst_s2) begin
            nxt_s.ack     = 1'b0;
            nxt_s.cmd     = '{data: '0, ce_n: 1'b1, oe_n: 1'b1,
                              latch_open: 1'b0};
            nxt_s.store   = '0;
            nxt_s.oe_n    = 1'b1;
            nxt_s.cap     = 1'b0;
            nxt_s.etg     = 1'b0;
            nxt_s.rpt     = '{store: '0, oe_n: 1'b1, cap: 1'b0};
            nxt_s.rpt_tgl = 1'b0;
        end else begin
            // word is stable once the toggle has crossed
            if (s_ff.req_s2 != s_ff.ack) begin
                nxt_s.cmd = lnk.cmd;
                nxt_s.ack = s_ff.req_s2;
            end
            nxt_s.oe_n = s_ff.cmd.oe_n;
            if (!s_ff.cmd.ce_n && !s_ff.cmd.latch_open) begin
                nxt_s.store = s_ff.cmd.data;
                nxt_s.cap   = ~s_ff.cap;
            end
            nxt_s.etg = ~s_ff.etg;
            if (s_ff.rack_s2 == s_ff.rpt_tgl &&
                s_ff.rpt != {s_ff.store, s_ff.oe_n, s_ff.cap}) begin
                nxt_s.rpt     = {s_ff.store, s_ff.oe_n, s_ff.cap};
                nxt_s.rpt_tgl = ~s_ff.rpt_tgl;
            end
        end
    end

    always_ff @(posedge fwd_clock) begin
        s_ff <= nxt_s;
    end

    assign lnk.cmd_ack_tgl = s_ff.ack;
    assign lnk.rpt         = s_ff.rpt;
    assign lnk.rpt_tgl     = s_ff.rpt_tgl;
    assign lnk.edge_tgl    = s_ff.etg;

endmodule

// ---- bxt_core.sv ----
// top of the registered bus transceiver: register slave, both data paths
// assumes an avalon-mm master on ref_clk and pins from outside its domain
`timescale 1ns/100ps

module bxt_core
    import bxt_pkg::*;
(
    // clock, reset, enable
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // register bus
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // link clocks
    input  wire logic              fwd_clock,
    input  wire logic              rev_clock,
    // card side pins
    input  wire logic [BXT_W-1:0]  card_side_bus_in,
    output logic      [BXT_W-1:0]  card_side_bus_out,
    output logic      [BXT_W-1:0]  card_side_bus_oe,
    // backplane side pins
    input  wire logic [BXT_W-1:0]  backplane_side_bus_in,
    output logic      [BXT_W-1:0]  backplane_side_bus_out,
    output logic      [BXT_W-1:0]  backplane_side_bus_oe,
    // clock pins
    input  wire logic              backplane_clock_in,
    output logic                   backplane_clock_out,
    output logic                   backplane_clock_oe,
    output logic                   returned_clock_out,
    output logic                   returned_clock_oe
);

    typedef struct packed {
        // register slave
        logic [BXT_CTRL_W-1:0] ctrl;
        logic                  wait_n;
        logic [31:0]           rdata;
        // pin and link edge toggle synchronisers
        logic [BXT_W-1:0]      a_s1;
        logic [BXT_W-1:0]      a_s2;
        logic [BXT_W-1:0]      b_s1;
        logic [BXT_W-1:0]      b_s2;
        logic                  rclk_s1;
        logic                  rclk_s2;
        logic                  rclk_d;
        logic                  bck_s1;
        logic                  bck_s2;
        logic                  etg_s1;
        logic                  etg_s2;
        logic                  etg_d;
        // crossings to and from the link stage
        bxt_cmd_type           cmd;
        logic                  cmd_tgl;
        logic                  ack_s1;
        logic                  ack_s2;
        logic                  rpt_s1;
        logic                  rpt_s2;
        logic                  rpt_ack;
        logic                  cap_seen;
        logic                  fwd_oe_n;
        // stored data of both directions
        logic [BXT_W-1:0]      b_store;
        logic [BXT_W-1:0]      a_store;
        // pin outputs
        logic [BXT_W-1:0]      a_out;
        logic [BXT_W-1:0]      a_oe;
        logic [BXT_W-1:0]      b_oe;
        logic                  bclk_out;
        logic                  bclk_oe;
        logic                  rclk_out;
        logic                  rclk_oe;
    } bxt_core_state_type;

    bxt_core_state_type s_ff;
    bxt_core_state_type nxt_s;

    bxt_link_if lnk ();

    bxt_fwd_link u_fwd_link (
        .fwd_clock (fwd_clock),
        .sys_rst   (sys_rst),
        .lnk       (lnk.link_side)
    );

    assign lnk.cmd         = s_ff.cmd;
    assign lnk.cmd_tgl     = s_ff.cmd_tgl;
    assign lnk.rpt_ack_tgl = s_ff.rpt_ack;

    // control fields, all active low except the latch opens
    logic fwd_ce_n;
    logic fwd_oe_n_req;
    logic fwd_latch;
    logic rev_ce_n;
    logic rev_oe_n;
    logic rev_latch;

    assign fwd_oe_n_req = s_ff.ctrl[BXT_FWD_OE_N_BIT];
    assign fwd_ce_n     = s_ff.ctrl[BXT_FWD_CE_N_BIT];
    assign fwd_latch    = s_ff.ctrl[BXT_FWD_LATCH_BIT];
    assign rev_oe_n     = s_ff.ctrl[BXT_REV_OE_N_BIT];
    assign rev_ce_n     = s_ff.ctrl[BXT_REV_CE_N_BIT];
    assign rev_latch    = s_ff.ctrl[BXT_REV_LATCH_BIT];

    // next stored words, computed ahead of the output drivers
    logic [BXT_W-1:0] b_next;
    logic [BXT_W-1:0] a_next;
    logic             fwd_oe_n_next;
    logic             rev_edge;
    logic             new_rpt;

    assign rev_edge = s_ff.rclk_s2 && !s_ff.rclk_d;
    assign new_rpt  = s_ff.rpt_s2 != s_ff.rpt_ack;

    always_comb begin
        b_next        = s_ff.b_store;
        fwd_oe_n_next = s_ff.fwd_oe_n;
        if (new_rpt) begin
            fwd_oe_n_next = lnk.rpt.oe_n;
        end
        if (fwd_latch) begin
            b_next = s_ff.a_s2;
        end else if (new_rpt && lnk.rpt.cap != s_ff.cap_seen) begin
            b_next = lnk.rpt.store;
        end
        // latch closed and no new capture: earlier value kept
    end

    always_comb begin
        a_next = s_ff.a_store;
        if (rev_latch) begin
            a_next = s_ff.b_s2;
        end else if (rev_edge && !rev_ce_n) begin
            a_next = s_ff.b_s2;
        end
    end

    // open drain: only a low bit pulls the backplane line
    logic [BXT_W-1:0] b_pull;

    genvar gi;
    generate
        for (gi = 0; gi < BXT_W; gi++) begin : g_od
            assign b_pull[gi] = !fwd_oe_n_next && !b_next[gi];
        end
    endgenerate

    // register read mux
    logic [31:0] rd_word;

    always_comb begin
        case (avs_address)
            BXT_ADDR_CTRL: rd_word = {26'h0, s_ff.ctrl};
            BXT_ADDR_STAT: rd_word = {30'h0, s_ff.bclk_out, s_ff.fwd_oe_n};
            BXT_ADDR_FWD:  rd_word = {15'h0, s_ff.b_store};
            BXT_ADDR_REV:  rd_word = {15'h0, s_ff.a_store};
            default:       rd_word = 32'h0;
        endcase
    end

    always_comb begin
        nxt_s = s_ff;
        // synchronisers: first stage read only by the second
        nxt_s.a_s1    = card_side_bus_in;
        nxt_s.a_s2    = s_ff.a_s1;
        nxt_s.b_s1    = backplane_side_bus_in;
        nxt_s.b_s2    = s_ff.b_s1;
        nxt_s.rclk_s1 = rev_clock;
        nxt_s.rclk_s2 = s_ff.rclk_s1;
        nxt_s.rclk_d  = s_ff.rclk_s2;
        nxt_s.bck_s1  = backplane_clock_in;
        nxt_s.bck_s2  = s_ff.bck_s1;
        nxt_s.etg_s1  = lnk.edge_tgl;
        nxt_s.etg_s2  = s_ff.etg_s1;
        nxt_s.etg_d   = s_ff.etg_s2;
        nxt_s.ack_s1  = lnk.cmd_ack_tgl;
        nxt_s.ack_s2  = s_ff.ack_s1;
        nxt_s.rpt_s1  = lnk.rpt_tgl;
        nxt_s.rpt_s2  = s_ff.rpt_s1;

        // slave: one wait cycle, then answer for exactly one cycle
        nxt_s.wait_n = 1'b0;
        if ((avs_read || avs_write) && !s_ff.wait_n) begin
            nxt_s.wait_n = 1'b1;
            nxt_s.rdata  = avs_read ? rd_word : 32'h0;
        end
        if (avs_write && s_ff.wait_n && avs_byteenable[0] &&
            avs_address == BXT_ADDR_CTRL) begin
            nxt_s.ctrl = avs_writedata[BXT_CTRL_W-1:0];
        end

        // send newest card data and controls once the last one landed
        if (s_ff.ack_s2 == s_ff.cmd_tgl &&
            s_ff.cmd != {s_ff.a_s2, fwd_ce_n, fwd_oe_n_req, fwd_latch}) begin
            nxt_s.cmd     = {s_ff.a_s2, fwd_ce_n, fwd_oe_n_req, fwd_latch};
            nxt_s.cmd_tgl = ~s_ff.cmd_tgl;
        end

        // take the link report; captures only count while latch is shut
        if (new_rpt) begin
            nxt_s.rpt_ack  = s_ff.rpt_s2;
            nxt_s.cap_seen = lnk.rpt.cap;
        end
        nxt_s.fwd_oe_n = fwd_oe_n_next;
        nxt_s.b_store  = b_next;
        nxt_s.a_store  = a_next;

        // backplane outputs gated by the registered forward enable
        nxt_s.b_oe     = b_pull;
        nxt_s.bclk_out = s_ff.etg_s2 ^ s_ff.etg_d;
        nxt_s.bclk_oe  = !fwd_oe_n_next;

        // card outputs follow the reverse enable with no link clock
        nxt_s.a_out    = a_next;
        nxt_s.a_oe     = {BXT_W{!rev_oe_n}};
        nxt_s.rclk_out = s_ff.bck_s2;
        nxt_s.rclk_oe  = !rev_oe_n;

        if (sys_rst) begin
            nxt_s.ctrl     = BXT_CTRL_RST;
            nxt_s.wait_n   = 1'b0;
            nxt_s.rdata    = 32'h0;
            nxt_s.cmd      = '{data: '0, ce_n: 1'b1, oe_n: 1'b1,
                               latch_open: 1'b0};
            nxt_s.cmd_tgl  = 1'b0;
            nxt_s.rpt_ack  = 1'b0;
            nxt_s.cap_seen = 1'b0;
            nxt_s.fwd_oe_n = 1'b1;
            nxt_s.b_store  = '0;
            nxt_s.a_store  = '0;
            nxt_s.a_out    = '0;
            nxt_s.a_oe     = '0;
            nxt_s.b_oe     = '0;
            nxt_s.bclk_out = 1'b0;
            nxt_s.bclk_oe  = 1'b0;
            nxt_s.rclk_out = 1'b0;
            nxt_s.rclk_oe  = 1'b0;
        end
    end

    // clk_en freezes this domain except under sys_rst; the link stage keeps clocking, only its handshakes wait
    always_ff @(posedge ref_clk) begin
        if (clk_en || sys_rst) begin
            s_ff <= nxt_s;
        end
    end

    assign avs_readdata           = s_ff.rdata;
    assign avs_waitrequest        = !s_ff.wait_n;
    assign card_side_bus_out      = s_ff.a_out;
    assign card_side_bus_oe       = s_ff.a_oe;
    assign backplane_side_bus_out = '0;
    assign backplane_side_bus_oe  = s_ff.b_oe;
    assign backplane_clock_out    = s_ff.bclk_out;
    assign backplane_clock_oe     = s_ff.bclk_oe;
    assign returned_clock_out     = s_ff.rclk_out;
    assign returned_clock_oe      = s_ff.rclk_oe;

endmodule

// ---- bxt_asserts.sv ----
// checker on the transceiver top: bus answer timing, enables, reset
// assumes clk_en stays high; bound into every bxt_core
`timescale 1ns/100ps
module bxt_asserts
    import bxt_pkg::*;
(
    // clock, reset and register bus
    input wire logic             ref_clk,
    input wire logic             sys_rst,
    input wire logic [3:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [3:0]       avs_byteenable,
    input wire logic [31:0]      avs_readdata,
    input wire logic             avs_waitrequest,
    // pin side
    input wire logic [BXT_W-1:0] card_side_bus_oe,
    input wire logic [BXT_W-1:0] backplane_side_bus_out,
    input wire logic             returned_clock_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_answer_next: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_answer_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held too long");
    a_unmapped_zero: assert property (
        avs_read && avs_waitrequest && avs_address[1:0] != 2'h0
        |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_open_drain_low: assert property (
        backplane_side_bus_out == '0) else $error("backplane driven high");
    a_card_oe_whole: assert property (
        card_side_bus_oe == '0 || card_side_bus_oe == '1)
        else $error("card enables split");
    a_rev_oe_pair: assert property (
        card_side_bus_oe[0] == returned_clock_oe)
        else $error("returned clock enable apart from card enable");
    a_rev_oe_on: assert property (
        avs_write && avs_waitrequest && avs_byteenable[0]
        && avs_address == BXT_ADDR_CTRL && !avs_writedata[BXT_REV_OE_N_BIT]
        |-> ##[1:3] returned_clock_oe) else $error("reverse enable missed");
    a_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> avs_waitrequest && card_side_bus_oe == '0
        && !returned_clock_oe) else $error("outputs live after reset");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_write: cover property (avs_write && !avs_waitrequest);
    c_card_on: cover property ($rose(returned_clock_oe));
endmodule
bind bxt_core bxt_asserts u_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .card_side_bus_oe(card_side_bus_oe),
    .backplane_side_bus_out(backplane_side_bus_out),
    .returned_clock_oe(returned_clock_oe));

// ---- bxt_far_model.sv ----
// far side: card logic on the card pins, pulled-up backplane lines
// assumes the bench sets the values each side would drive
`timescale 1ns/100ps
module bxt_far_model
    import bxt_pkg::*;
(
    // bench controls
    input  wire logic             fwd_run,
    input  wire logic [BXT_W-1:0] card_val,
    input  wire logic [BXT_W-1:0] bp_val,
    // design outputs
    input  wire logic [BXT_W-1:0] card_out,
    input  wire logic [BXT_W-1:0] card_oe,
    input  wire logic [BXT_W-1:0] bp_oe,
    input  wire logic             bclk_out,
    input  wire logic             bclk_oe,
    // resolved lines
    output logic                  fwd_clock,
    output logic      [BXT_W-1:0] card_wire,
    output logic      [BXT_W-1:0] bp_wire,
    output logic                  bclk_wire
);
    // stands still while stopped, so enable changes cannot sneak through
    initial begin
        fwd_clock = 1'b0;
        #7;
        forever begin
            #16;
            if (fwd_run) fwd_clock = ~fwd_clock;
        end
    end
    assign card_wire = (card_oe & card_out) | (~card_oe & card_val);
    // low if either side pulls
    assign bp_wire = ~bp_oe & bp_val;
    assign bclk_wire = bclk_oe ? bclk_out : 1'b1;
endmodule

// ---- tb_top.sv ----
// bench: avalon master tasks walking every mode of both data paths
// assumes the far model resolves pins and runs the forward clock
`timescale 1ns/100ps
module tb_top;
    import bxt_pkg::*;
    logic             ref_clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             fwd_run = 1'b1;
    logic             rev_clock = 1'b0;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [3:0]       avs_address = 4'h0;
    logic [3:0]       avs_byteenable = 4'hf;
    logic [31:0]      avs_writedata = 32'h0;
    logic [BXT_W-1:0] card_val = 17'h0;
    logic [BXT_W-1:0] bp_val = 17'h1ffff;
    logic [31:0]      avs_readdata, rd;
    logic             avs_waitrequest, fwd_clock, bclk_in, bclk_out;
    logic             bclk_oe, rclk_out, rclk_oe;
    logic [BXT_W-1:0] card_in, card_out, card_oe, bp_in, bp_out, bp_oe;
    int               mismatches = 0;
    int               cmp_count = 0;
    int               pulses = 0;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (bclk_out === 1'b1 && bclk_oe === 1'b1) pulses <= pulses + 1;
    bxt_far_model far (
        .fwd_run(fwd_run), .card_val(card_val), .bp_val(bp_val),
        .card_out(card_out), .card_oe(card_oe), .bp_oe(bp_oe),
        .bclk_out(bclk_out), .bclk_oe(bclk_oe), .fwd_clock(fwd_clock),
        .card_wire(card_in), .bp_wire(bp_in), .bclk_wire(bclk_in));
    bxt_core dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fwd_clock(fwd_clock),
        .rev_clock(rev_clock), .card_side_bus_in(card_in),
        .card_side_bus_out(card_out), .card_side_bus_oe(card_oe),
        .backplane_side_bus_in(bp_in), .backplane_side_bus_out(bp_out),
        .backplane_side_bus_oe(bp_oe), .backplane_clock_in(bclk_in),
        .backplane_clock_out(bclk_out), .backplane_clock_oe(bclk_oe),
        .returned_clock_out(rclk_out), .returned_clock_oe(rclk_oe));
    task automatic report_and_stop;
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pin(input logic [BXT_W-1:0] s, input logic [BXT_W-1:0] e);
        check({15'h0, s}, {15'h0, e});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            mismatches++;
            report_and_stop();
        end
        // one idle edge so the strobe is never reassigned in this step
        @(posedge ref_clk);
    endtask
    task automatic ctrl(input logic [31:0] d);
        bus(1'b1, BXT_ADDR_CTRL, d, 4'hf, rd);
    endtask
    task automatic rd_check(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf, rd);
        check(rd, e);
    endtask
    task automatic rev_pulse;
        rev_clock <= 1'b1;
        idle(4);
        rev_clock <= 1'b0;
        idle(20);
    endtask
    initial begin
        idle(8);
        sys_rst <= 1'b0;
        idle(1);
        rd_check(BXT_ADDR_CTRL, 32'h1b);
        rd_check(4'h2, 32'h0);
        bus(1'b1, BXT_ADDR_CTRL, 32'h0, 4'h0, rd);
        rd_check(BXT_ADDR_CTRL, 32'h1b);
        ctrl(32'h1e);
        card_val <= 17'h15a3c;
        idle(30);
        pin(bp_in, 17'h15a3c);
        check({31'h0, bclk_oe}, 32'h1);
        check(32'(pulses > 0), 32'h1);
        rd_check(BXT_ADDR_FWD, 32'h15a3c);
        ctrl(32'h1a);
        card_val <= 17'h0a5c3;
        idle(30);
        pin(bp_in, 17'h15a3c);
        ctrl(32'h18);
        idle(40);
        pin(bp_in, 17'h0a5c3);
        ctrl(32'h19);
        idle(30);
        pin(bp_in, 17'h1ffff);
        check({31'h0, bclk_oe}, 32'h0);
        fwd_run <= 1'b0;
        ctrl(32'h18);
        idle(30);
        pin(bp_in, 17'h1ffff);
        fwd_run <= 1'b1;
        idle(40);
        pin(bp_in, 17'h0a5c3);
        bp_val <= 17'h1c3a5;
        ctrl(32'h33);
        idle(20);
        pin(card_in, 17'h1c3a5);
        pin(card_oe, 17'h1ffff);
        // released backplane clock line sits at its pull-up level
        check({30'h0, rclk_oe, rclk_out}, 32'h3);
        rd_check(BXT_ADDR_REV, 32'h1c3a5);
        ctrl(32'h03);
        bp_val <= 17'h03c5a;
        idle(20);
        pin(card_in, 17'h1c3a5);
        rev_pulse();
        pin(card_in, 17'h03c5a);
        ctrl(32'h13);
        bp_val <= 17'h1c3a5;
        rev_pulse();
        pin(card_in, 17'h03c5a);
        ctrl(32'h0b);
        idle(4);
        pin(card_oe, 17'h0);
        check({31'h0, rclk_oe}, 32'h0);
        report_and_stop();
    end
endmodule
